//--- hdl/ebma_arbiter.sv
// External bus mastership arbiter: hands the memory bus between this
// device and one external master over an active-low request/acknowledge.
// Assumes the bus state controller reports its cycle activity on sys_clk,
// and that the pad ring resolves pins from the enables given here.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Device owns bus after reset, releases only on external request.
// - All control strobes are driven inactive before the bus is released.
// - On reclaim, strobes are driven inactive first, accesses resume later.
// - Hand-over only between cycles; a running cycle finishes first.
// - Idle wait cycles between accesses count as an active cycle.
// - No release during line fill, copyback, TEST_AND_SET_INSTR gap, split cycles, 16-byte DMA.
// - No grant during SDRAM self-refresh, clock stop or reset.
// - Refresh and bus requests are still taken during burst DMA.
// - Request low: finish cycle, release bus, assert acknowledge low.
// - Master returns the bus by raising request; device then resumes.
// - Open SDRAM banks get a precharge-all before the bus is released.
// - Float address/data on rise, acknowledge on fall, strobes on next rise.
// - The request input is sampled only on falling bus clock edges.
// - Negation seen on a fall; acknowledge negated next fall; drive next rise.
// - Power-on reset negates outputs, disables buffers, resets all state.
// - Manual reset keeps state, finishes the cycle, then waits for access.
// - Refresh counter runs through manual reset and raises refresh requests.
// - Bus requests are ignored while manual reset is asserted.
module ebma_arbiter
  import ebma_pkg::*;
#(
  parameter int REFRESH_NS = 15600
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ext_bus_request_n,
  input wire logic manual_reset_n,
  input wire ebma_core_t core,
  input wire ebma_no_release_t no_release,
  input wire logic precharge_all_cmd_done,
  input wire logic refresh_done,
  output logic bus_clock_out,
  output logic bus_ack_n,
  output ebma_pad_t pad,
  output logic precharge_all_cmd,
  output logic core_hold,
  output logic ext_owns,
  output logic refresh_pending,
  output logic refresh_start
);

  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------
  // A longest interval, so the division rounds down
  localparam int REFRESH_CYC = REFRESH_NS / SYS_PERIOD_NS;
  localparam logic [REFRESH_CNT_W-1:0] REFRESH_LAST = REFRESH_CNT_W'(REFRESH_CYC - 1);
  localparam logic [REFRESH_CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [REFRESH_CNT_W-1:0] CNT_ONE = REFRESH_CNT_W'(1);

  ebma_state_t state_ff;
  ebma_state_t nxt_state;
  logic bclk_ff;
  logic req_s1_ff;
  logic req_s2_ff;
  logic mrst_s1_ff;
  logic mrst_s2_ff;
  logic ack_n_ff;
  logic ad_oe_n_ff;
  logic ctrl_oe_n_ff;
  logic ctrl_negate_ff;
  logic precharge_all_cmd_ff;
  logic refresh_req_ff;
  logic [REFRESH_CNT_W-1:0] refresh_cnt_ff;
  logic rise_tick;
  logic fall_tick;
  logic mrst;
  logic req_low_at_fall;
  logic req_high_at_fall;
  logic busy;
  logic stopped;

  // ----------------------------------------------------------------
  // Bus clock divider
  // ----------------------------------------------------------------
  // Toggle each sys_clk; the edge on which bclk_ff goes high is a rise tick
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bclk_ff <= BCLK_RESET;
    end else begin
      bclk_ff <= ~bclk_ff;
    end
  end

  assign rise_tick = ~bclk_ff;
  assign fall_tick = bclk_ff;
  assign bus_clock_out = bclk_ff;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Both pins are asynchronous; only the second stage is looked at
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_s1_ff <= PIN_NEGATED;
      req_s2_ff <= PIN_NEGATED;
      mrst_s1_ff <= PIN_NEGATED;
      mrst_s2_ff <= PIN_NEGATED;
    end else begin
      req_s1_ff <= ext_bus_request_n;
      req_s2_ff <= req_s1_ff;
      mrst_s1_ff <= manual_reset_n;
      mrst_s2_ff <= mrst_s1_ff;
    end
  end

  // Request is judged only in fall ticks
  assign req_low_at_fall = fall_tick & ~req_s2_ff;
  assign req_high_at_fall = fall_tick & req_s2_ff;
  assign mrst = ~mrst_s2_ff;

  // ----------------------------------------------------------------
  // Release gating
  // ----------------------------------------------------------------
  // Idle waits count as busy even though no strobe shows it
  assign busy = core.cycle_active | core.idle_wait_active | (|no_release);
  // The external master is expected to be asleep meanwhile
  assign stopped = core.self_refresh | core.clock_stopping;

  // ----------------------------------------------------------------
  // Arbitration sequence
  // ----------------------------------------------------------------
  // Burst DMA is deliberately not a blocking term here
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_OWN: begin
        if (req_low_at_fall && !mrst) begin
          nxt_state = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (req_high_at_fall || mrst) begin
          nxt_state = S_OWN;
        end else if (!busy && !stopped) begin
          nxt_state = core.banks_open ? S_PRECHARGE_ALL_CMD : S_NEGATE;
        end
      end
      S_PRECHARGE_ALL_CMD: begin
        if (precharge_all_cmd_done) begin
          nxt_state = S_NEGATE;
        end
      end
      S_NEGATE: begin
        if (rise_tick && ctrl_negate_ff) begin
          nxt_state = S_ACK_WAIT;
        end
      end
      S_ACK_WAIT: begin
        if (fall_tick) begin
          nxt_state = S_CTL_FLOAT;
        end
      end
      S_CTL_FLOAT: begin
        if (rise_tick) begin
          nxt_state = S_EXT;
        end
      end
      S_EXT: begin
        if (req_high_at_fall) begin
          nxt_state = S_RECLAIM;
        end
      end
      S_RECLAIM: begin
        if (fall_tick) begin
          nxt_state = S_REDRIVE;
        end
      end
      S_REDRIVE: begin
        if (rise_tick) begin
          nxt_state = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (rise_tick) begin
          nxt_state = S_OWN;
        end
      end
    endcase
  end

  // After power-on the pins come back through the redrive steps
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= S_REDRIVE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge output
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_n_ff <= PIN_NEGATED;
    end else if (state_ff == S_ACK_WAIT && fall_tick) begin
      ack_n_ff <= PIN_ASSERTED;
    end else if (state_ff == S_RECLAIM && fall_tick) begin
      ack_n_ff <= PIN_NEGATED;
    end
  end

  // ----------------------------------------------------------------
  // Address and data buffer enable
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ad_oe_n_ff <= OE_OFF;
    end else if (state_ff == S_NEGATE && rise_tick && ctrl_negate_ff) begin
      ad_oe_n_ff <= OE_OFF;
    end else if (state_ff == S_REDRIVE && rise_tick) begin
      ad_oe_n_ff <= OE_ON;
    end
  end

  // ----------------------------------------------------------------
  // Control strobe enable and forced negation
  // ----------------------------------------------------------------
  // Strobes float one bus clock after address, so the pull-ups see no glitch
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_oe_n_ff <= OE_OFF;
    end else if (state_ff == S_CTL_FLOAT && rise_tick) begin
      ctrl_oe_n_ff <= OE_OFF;
    end else if (state_ff == S_REDRIVE && rise_tick) begin
      ctrl_oe_n_ff <= OE_ON;
    end
  end

  // Negation starts before the float and lasts a bus clock after redrive
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_negate_ff <= 1'b1;
    end else if (nxt_state == S_NEGATE) begin
      ctrl_negate_ff <= 1'b1;
    end else if (state_ff == S_SETTLE && rise_tick) begin
      ctrl_negate_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Precharge-all request
  // ----------------------------------------------------------------
  // Held as a level until the SDRAM controller reports completion
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      precharge_all_cmd_ff <= 1'b0;
    end else begin
      precharge_all_cmd_ff <= (nxt_state == S_PRECHARGE_ALL_CMD) && !precharge_all_cmd_done;
    end
  end

  // ----------------------------------------------------------------
  // Refresh counter
  // ----------------------------------------------------------------
  // Only power-on reset clears it; manual reset leaves it running
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      refresh_cnt_ff <= CNT_ZERO;
    end else if (refresh_cnt_ff == REFRESH_LAST) begin
      refresh_cnt_ff <= CNT_ZERO;
    end else begin
      refresh_cnt_ff <= refresh_cnt_ff + CNT_ONE;
    end
  end

  // A new request wins over a completion in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      refresh_req_ff <= 1'b0;
    end else if (refresh_cnt_ff == REFRESH_LAST) begin
      refresh_req_ff <= 1'b1;
    end else if (refresh_done) begin
      refresh_req_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus_ack_n = ack_n_ff;
  assign pad = '{ad_oe_n: ad_oe_n_ff, ctrl_oe_n: ctrl_oe_n_ff, ctrl_negate: ctrl_negate_ff};
  assign precharge_all_cmd = precharge_all_cmd_ff;
  // Manual reset lets the running cycle end, then holds new accesses
  assign core_hold = (state_ff != S_OWN) | mrst;
  assign ext_owns = (state_ff == S_EXT);
  assign refresh_pending = refresh_req_ff;
  // Refresh may start even in manual reset or burst DMA
  assign refresh_start = refresh_req_ff & (state_ff == S_OWN) & ~core.cycle_active;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_negation_seen;
    state_ff == S_EXT && req_high_at_fall;
  endsequence

  sequence seq_release_go;
    state_ff == S_DRAIN && !req_high_at_fall && !mrst && !busy && !stopped;
  endsequence

  AST_ACK_ON_FALL: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(ack_n_ff) |-> !bclk_ff && ad_oe_n_ff && $past(ad_oe_n_ff))
    else $error("acknowledge not on a fall after address float");

  AST_CTRL_FLOAT_ON_RISE: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(ctrl_oe_n_ff) |-> bclk_ff && !ack_n_ff && ctrl_negate_ff)
    else $error("strobes floated at wrong moment");

  AST_NEGATE_BEFORE_FLOAT: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(ad_oe_n_ff) |-> $past(ctrl_negate_ff) && !ctrl_oe_n_ff)
    else $error("bus released with strobes not negated");

  AST_HOLD_WHILE_BUSY: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_ff == S_DRAIN && (busy || stopped) |=> state_ff inside {S_DRAIN, S_OWN})
    else $error("bus released during a cycle or a blocked state");

  AST_PRECHARGE_ALL_CMD_FIRST: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_release_go ##0 core.banks_open |=> state_ff == S_PRECHARGE_ALL_CMD ##1 precharge_all_cmd_ff || precharge_all_cmd_done)
    else $error("release with banks open skipped precharge");

  AST_EXT_FLOATED: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_ff == S_EXT |-> ad_oe_n_ff && ctrl_oe_n_ff && !ack_n_ff)
    else $error("pins driven while external master owns bus");

  AST_MRST_IGNORES_REQ: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_ff == S_OWN && mrst |=> state_ff == S_OWN)
    else $error("request taken during manual reset");

  AST_RECLAIM_TIMING: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_negation_seen |-> ##3 $rose(ack_n_ff) ##1 !ad_oe_n_ff && !ctrl_oe_n_ff && ctrl_negate_ff)
    else $error("reclaim sequence timing wrong");

  AST_INACTIVE_ON_REDRIVE: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(ctrl_oe_n_ff) |-> ctrl_negate_ff ##1 ctrl_negate_ff && core_hold)
    else $error("strobes redriven without negation first");

  AST_REFRESH_RAISED: assert property (@(posedge sys_clk) disable iff (!rstn)
    refresh_cnt_ff == REFRESH_LAST |=> refresh_req_ff && refresh_cnt_ff == CNT_ZERO)
    else $error("refresh request not raised at terminal count");

endmodule : ebma_arbiter

`default_nettype wire

//--- hdl/ebma_pkg.sv
// Shared constants, carriers and state codes for the external bus
// mastership arbiter.
// Assumes one 100 MHz system clock from which the bus clock is divided.
package ebma_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 10;
  localparam int REFRESH_CNT_W = 16;

  // ----------------------------------------------------------------
  // Reset and idle levels of the pins
  // ----------------------------------------------------------------
  localparam logic PIN_NEGATED = 1'b1;
  localparam logic PIN_ASSERTED = 1'b0;
  localparam logic OE_OFF = 1'b1;
  localparam logic OE_ON = 1'b0;
  localparam logic BCLK_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Core sequences during which the bus must stay with the device
  typedef struct packed {
    logic line_fill;
    logic copyback;
    logic tas_gap;
    logic split_cycle;
    logic dma_16byte;
  } ebma_no_release_t;

  // Core activity, conditions that forbid a grant, and open SDRAM banks
  typedef struct packed {
    logic cycle_active;
    logic idle_wait_active;
    logic self_refresh;
    logic clock_stopping;
    logic banks_open;
  } ebma_core_t;

  // Pin side controls toward the pad ring
  typedef struct packed {
    logic ad_oe_n;
    logic ctrl_oe_n;
    logic ctrl_negate;
  } ebma_pad_t;

  // ----------------------------------------------------------------
  // Arbiter states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_OWN,
    S_DRAIN,
    S_PRECHARGE_ALL_CMD,
    S_NEGATE,
    S_ACK_WAIT,
    S_CTL_FLOAT,
    S_EXT,
    S_RECLAIM,
    S_REDRIVE,
    S_SETTLE
  } ebma_state_t;

endpackage : ebma_pkg

//--- tb/ebma_ext_master.sv
// External master model sharing the memory bus with the arbiter.
// Assumes the bench drives want and sleep just after rising edges.
`timescale 1ns/100ps
`default_nettype none
module ebma_ext_master #(
  parameter int MAX_HOLD = 64
) (
  input wire logic sys_clk,
  input wire logic want,
  input wire logic sleep,
  input wire logic bus_ack_n,
  output logic ext_bus_request_n
);
  // ----------------------------------------------------------------
  // Request handshake
  // ----------------------------------------------------------------
  int held = 0;
  logic spent = 1'b0;
  logic w, s, a;
  initial ext_bus_request_n = 1'b1;
  // Samples on the edge, answers a little later like a real pin
  always @(posedge sys_clk) begin
    w = want;
    s = sleep;
    a = bus_ack_n;
    #1;
    held = a ? 0 : held + 1;
    if (s) begin
      ext_bus_request_n = 1'b1;
    end else if (ext_bus_request_n && w && !spent && a) begin
      ext_bus_request_n = 1'b0;
    end else if (!ext_bus_request_n && !a && (!w || held >= MAX_HOLD)) begin
      // Bounded tenure keeps refresh possible; many cycles per grant
      ext_bus_request_n = 1'b1;
      spent = w;
    end
    if (!w) spent = 1'b0;
  end
endmodule : ebma_ext_master
`default_nettype wire

//--- tb/test_external_bus_mastership_arbiter.sv
// Self-checking bench for the bus mastership arbiter.
// Assumes the external master model sits on the request pin.
`timescale 1ns/100ps
`default_nettype none
module test_external_bus_mastership_arbiter import ebma_pkg::*;;
  // ----------------------------------------------------------------
  // Stimulus, instances and checks
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic manual_reset_n = 1'b1;
  logic want = 1'b0;
  logic sleep = 1'b0;
  logic precharge_all_cmd_done = 1'b0;
  logic refresh_done = 1'b0;
  ebma_core_t core = '0;
  ebma_no_release_t no_release = '0;
  ebma_pad_t pad;
  logic ext_bus_request_n, bus_clock_out, bus_ack_n, precharge_all_cmd;
  logic core_hold, ext_owns, refresh_pending, refresh_start;
  int bad_count = 0;
  int num_checks = 0;
  // Small refresh interval keeps the run short: 20 cycles
  ebma_arbiter #(.REFRESH_NS(200)) ebma_arbiter_i (
    .sys_clk(sys_clk), .rstn(rstn), .ext_bus_request_n(ext_bus_request_n),
    .manual_reset_n(manual_reset_n), .core(core), .no_release(no_release),
    .precharge_all_cmd_done(precharge_all_cmd_done), .refresh_done(refresh_done), .bus_clock_out(bus_clock_out),
    .bus_ack_n(bus_ack_n), .pad(pad), .precharge_all_cmd(precharge_all_cmd),
    .core_hold(core_hold), .ext_owns(ext_owns), .refresh_pending(refresh_pending),
    .refresh_start(refresh_start));
  // Tenure bound stays below the 20-cycle refresh interval used here
  ebma_ext_master #(.MAX_HOLD(16)) ebma_ext_master_i (
    .sys_clk(sys_clk), .want(want), .sleep(sleep), .bus_ack_n(bus_ack_n),
    .ext_bus_request_n(ext_bus_request_n));
  always #5 sys_clk = ~sys_clk;
  // Inputs change 1 ns after the edge, outputs sampled there too
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic check_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic check_pad(input string what, input ebma_pad_t exp, input ebma_pad_t got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_pad
  function automatic logic probe(input int k);
    case (k)
      0: return bus_ack_n;
      1: return precharge_all_cmd;
      default: return refresh_pending;
    endcase
  endfunction : probe
  // Bounded wait so a stuck handshake cannot hang the run
  task automatic wait_for(input int k, input logic lvl, input int limit, output logic hit);
    int n;
    hit = 1'b0;
    for (n = 0; n < limit && !hit; n++) begin
      tick(1);
      hit = (probe(k) === lvl);
    end
  endtask : wait_for
  task automatic give_back();
    logic hit;
    want = 1'b0;
    wait_for(0, 1'b1, 20, hit);
    check_bit("ack returned", 1'b1, hit);
    tick(8);
  endtask : give_back
  task automatic t_grant();
    logic hit;
    want = 1'b1;
    wait_for(0, 1'b0, 16, hit);
    check_bit("idle grant", 1'b1, hit);
    check_pad("pad at ack", 3'b101, pad);
    check_bit("bclk at ack", 1'b0, bus_clock_out);
    tick(1);
    check_pad("pad floated", 3'b111, pad);
    tick(10);
    check_bit("ack held", 1'b0, bus_ack_n);
    check_bit("ext owns", 1'b1, ext_owns);
    want = 1'b0;
    wait_for(0, 1'b1, 12, hit);
    check_bit("ack negated", 1'b1, hit);
    check_pad("pad at reclaim", 3'b111, pad);
    check_bit("bclk at reclaim", 1'b0, bus_clock_out);
    tick(1);
    check_pad("redrive", 3'b001, pad);
    check_bit("core still held", 1'b1, core_hold);
    tick(2);
    check_pad("pad resumed", 3'b000, pad);
    check_bit("core resumed", 1'b0, core_hold);
    tick(6);
  endtask : t_grant
  // Each blocking condition alone; bit 5 is banks_open, tested apart
  task automatic t_block();
    logic hit;
    int i;
    for (i = 0; i < 10; i++) begin
      if (i != 5) begin
        {core, no_release} = 10'h001 << i;
        want = 1'b1;
        tick(30);
        check_bit("blocked ack", 1'b1, bus_ack_n);
        {core, no_release} = 10'h000;
        wait_for(0, 1'b0, 16, hit);
        check_bit("late grant", 1'b1, hit);
        give_back();
      end
    end
  endtask : t_block
  task automatic t_precharge_all_cmd();
    logic hit;
    core.banks_open = 1'b1;
    want = 1'b1;
    wait_for(1, 1'b1, 16, hit);
    check_bit("precharge issued", 1'b1, hit);
    tick(10);
    check_bit("held for precharge", 1'b1, bus_ack_n);
    precharge_all_cmd_done = 1'b1;
    core.banks_open = 1'b0;
    tick(1);
    precharge_all_cmd_done = 1'b0;
    wait_for(0, 1'b0, 16, hit);
    check_bit("grant after precharge", 1'b1, hit);
    give_back();
  endtask : t_precharge_all_cmd
  task automatic t_mrst();
    logic hit;
    manual_reset_n = 1'b0;
    tick(4);
    check_bit("core held", 1'b1, core_hold);
    refresh_done = 1'b1;
    tick(1);
    refresh_done = 1'b0;
    wait_for(2, 1'b1, 30, hit);
    check_bit("refresh in manual reset", 1'b1, hit);
    check_bit("refresh start", 1'b1, refresh_start);
    want = 1'b1;
    tick(30);
    check_bit("request ignored", 1'b1, bus_ack_n);
    manual_reset_n = 1'b1;
    wait_for(0, 1'b0, 20, hit);
    check_bit("grant after manual", 1'b1, hit);
    give_back();
  endtask : t_mrst
  // Power-on reset while the master owns the bus
  task automatic t_por();
    logic hit;
    want = 1'b1;
    wait_for(0, 1'b0, 16, hit);
    rstn = 1'b0;
    tick(2);
    check_pad("reset in grant", 3'b111, pad);
    check_bit("ack in reset", 1'b1, bus_ack_n);
    tick(10);
    rstn = 1'b1;
    wait_for(0, 1'b0, 30, hit);
    check_bit("grant after reset", 1'b1, hit);
    give_back();
  endtask : t_por
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    tick(12);
    check_pad("reset pad", 3'b111, pad);
    check_bit("reset ack", 1'b1, bus_ack_n);
    check_bit("reset owner", 1'b0, ext_owns);
    rstn = 1'b1;
    tick(8);
    check_pad("owned pad", 3'b000, pad);
    check_bit("owned ack", 1'b1, bus_ack_n);
    check_bit("core free", 1'b0, core_hold);
    t_grant();
    t_block();
    t_precharge_all_cmd();
    t_mrst();
    t_por();
    end_sim();
  end
  // Whole sequence takes under 1500 cycles
  initial begin
    #100000;
    bad_count++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    end_sim();
  end
endmodule : test_external_bus_mastership_arbiter
`default_nettype wire
